// *** hdl/hbd_pkg.sv ***
/*
 * Shared constants and carrier types of the bridge driver control slice.
 * Assumes a 32-bit AXI4-Lite register bus and a 100 MHz system clock.
 */
package hbd_pkg;

   // ----------------------------------------------------------------
   // Bus geometry and answers
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h40;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h44;

   // ----------------------------------------------------------------
   // Field layout of the control word, one byte per driver
   // ----------------------------------------------------------------
   localparam int NUM_DRV = 2;
   localparam int IDX_HIGH1 = 0;
   localparam int IDX_LOW2 = 1;
   localparam int HIGH1_BASE = 16;
   localparam int LOW2_BASE = 8;
   localparam int F_SCOPE = 7;
   localparam int F_OCFLAG = 6;
   localparam int F_SUPPLY = 5;
   localparam int F_SHORT = 4;
   localparam int F_DIAG = 3;
   localparam int F_ON = 2;
   localparam int F_PWM = 1;
   localparam int F_POWER = 0;
   localparam logic RESET_POWER = 1'h1;
   localparam logic RESET_OTHER = 1'h0;

   // ----------------------------------------------------------------
   // Interrupt status layout
   // ----------------------------------------------------------------
   localparam int NUM_EV = 6;
   localparam int EV_OC_LSB = 0;
   localparam int EV_SUP_LSB = 2;
   localparam int EV_SHORT_LSB = 4;
   localparam logic [NUM_EV-1:0] MASK_RESET = 6'h00;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef enum {HBD_SEL_CTRL, HBD_SEL_IRQ_STS, HBD_SEL_IRQ_MASK, HBD_SEL_NONE} hbd_sel_t;

   typedef struct packed {
      logic overcurrent;
      logic drain_supply_flag;
      logic pump_supply_flag;
      logic short_seen;
   } hbd_sense_t;

   typedef struct packed {
      logic power;
      logic gate;
      logic diag_source;
   } hbd_drive_t;

   localparam int SENSE_W = $bits(hbd_sense_t);

endpackage

// *** hdl/hbd_sync.sv ***
/*
 * Three-stage input filter for levels from outside the clock domain.
 * Assumes inputs may change at any time; output moves only when stages two and three agree.
 */
`timescale 1ns/1ps
module hbd_sync import hbd_pkg::*; #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;

   // The first stage feeds the second stage only, to keep metastability contained.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   genvar i;
   for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            sync_out[i] <= 1'b0;
         end else if (s2_ff[i] == s3_ff[i]) begin
            sync_out[i] <= s3_ff[i];
         end
      end
   end

endmodule

// *** hdl/hbd_irq.sv ***
/*
 * Sticky event status with mask and one level interrupt.
 * Assumes events are one-cycle pulses from the same clock domain.
 */
`timescale 1ns/1ps
module hbd_irq import hbd_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NUM_EV-1:0] events,
   input wire logic read_clear,
   input wire logic mask_write,
   input wire logic [NUM_EV-1:0] mask_data,
   output logic [NUM_EV-1:0] status,
   output logic [NUM_EV-1:0] mask,
   output logic irq
);

   // A new event in the clearing cycle survives, so no event is lost.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= '0;
      end else begin
         status <= (status & ~{NUM_EV{read_clear}}) | events;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask <= MASK_RESET;
      end else if (mask_write) begin
         mask <= mask_data;
      end
   end

   assign irq = |(status & mask);

endmodule

// *** hdl/hbd_slice.sv ***
/*
 * Control and status slice of the bridge driver control word for high-side driver 1
 * and low-side driver 2, with an AXI4-Lite register slave and an event interrupt.
 * Assumes RST_N is the type-3 reset, sense inputs and PWM are asynchronous pins,
 * and the remaining drivers sit outside and exchange a global shutdown level.
 */
// Design decisions made here: the address map and the AXI4-Lite register port.
//
// Summary of operation
// - A driver's overcurrent shuts down all bridges when its scope bit is 0 and only its own bridge when 1.
// - An overcurrent sets the driver's read-only overcurrent flag and switches the driver off automatically.
// - The supply fault flag reads the OR of the drain supply flag and the pump supply flag.
// - The short monitor flag reads a detected short, and is only meaningful once the high-side diag source is on.
// - Writing 1 to the high-side driver 1 diag enable turns its diagnosis current source on while its driver enable is 1, writing 0 turns it off.
// - The low-side driver 2 diag enable is stored and read back but drives nothing.
// - The on flag switches the driver on at 1 and off at 0, and hardware may also change it.
// - The PWM enable puts the driver under control of the PWM input, and hardware may also change it.
// - The driver enable bit powers the driver circuit on at 1 and off at 0.
// - The control word returns to its reset value only on the type-3 reset.
`timescale 1ns/1ps
module hbd_slice import hbd_pkg::*; (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [DATA_W-1:0] S_AXI_WDATA,
   input wire logic [STRB_W-1:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [DATA_W-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic PWM_IN,
   input wire hbd_sense_t HIGH1_SENSE,
   input wire hbd_sense_t LOW2_SENSE,
   input wire logic GLOBAL_SHUTDOWN_IN,
   output hbd_drive_t HIGH1_DRIVE,
   output hbd_drive_t LOW2_DRIVE,
   output logic GLOBAL_SHUTDOWN_OUT,
   output logic ALL_DRIVERS_POWERED,
   output logic IRQ
);

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic hbd_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
      hbd_sel_t sel;
      sel = HBD_SEL_NONE;
      if (addr == OFS_CTRL_ONE) begin
         sel = HBD_SEL_CTRL;
      end else if (addr == OFS_IRQ_STATUS) begin
         sel = HBD_SEL_IRQ_STS;
      end else if (addr == OFS_IRQ_MASK) begin
         sel = HBD_SEL_IRQ_MASK;
      end
      return sel;
   endfunction

   function automatic int drv_base(input int d);
      return (d == IDX_HIGH1) ? HIGH1_BASE : LOW2_BASE;
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   localparam int SYNC_W = 2 * SENSE_W + 2;

   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync_in;
   hbd_sense_t sense_s [NUM_DRV];
   logic pwm_s;
   logic global_s;

   assign raw_in = {GLOBAL_SHUTDOWN_IN, PWM_IN, LOW2_SENSE, HIGH1_SENSE};

   hbd_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk(CLK),
      .rst_n(RST_N),
      .async_in(raw_in),
      .sync_out(sync_in)
   );

   assign sense_s[IDX_HIGH1] = sync_in[SENSE_W-1:0];
   assign sense_s[IDX_LOW2] = sync_in[2*SENSE_W-1:SENSE_W];
   assign pwm_s = sync_in[2*SENSE_W];
   assign global_s = sync_in[2*SENSE_W+1];

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic aw_hold_ff;
   logic [ADDR_W-1:0] aw_addr_ff;
   logic w_hold_ff;
   logic [DATA_W-1:0] w_data_ff;
   logic [STRB_W-1:0] w_strb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic do_write;
   hbd_sel_t wr_sel;
   logic wr_ctrl;

   assign S_AXI_AWREADY = !aw_hold_ff;
   assign S_AXI_WREADY = !w_hold_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign wr_sel = decode_addr(aw_addr_ff);
   assign wr_ctrl = do_write && (wr_sel == HBD_SEL_CTRL);

   // Address and data are caught separately, so the master may offer them in either order.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_hold_ff <= 1'b0;
         aw_addr_ff <= '0;
      end else if (do_write) begin
         aw_hold_ff <= 1'b0;
      end else if (S_AXI_AWVALID && !aw_hold_ff) begin
         aw_hold_ff <= 1'b1;
         aw_addr_ff <= S_AXI_AWADDR;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         w_hold_ff <= 1'b0;
         w_data_ff <= '0;
         w_strb_ff <= '0;
      end else if (do_write) begin
         w_hold_ff <= 1'b0;
      end else if (S_AXI_WVALID && !w_hold_ff) begin
         w_hold_ff <= 1'b1;
         w_data_ff <= S_AXI_WDATA;
         w_strb_ff <= S_AXI_WSTRB;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (wr_sel == HBD_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (S_AXI_BREADY) begin
         bvalid_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Driver control bits
   // ----------------------------------------------------------------
   logic [NUM_DRV-1:0] scope_ff;
   logic [NUM_DRV-1:0] ocflag_ff;
   logic [NUM_DRV-1:0] diag_ff;
   logic [NUM_DRV-1:0] on_ff;
   logic [NUM_DRV-1:0] pwm_ff;
   logic [NUM_DRV-1:0] power_ff;
   logic [NUM_DRV-1:0] gate_ff;
   logic [NUM_DRV-1:0] oc_now;
   logic [NUM_DRV-1:0] supply_flag;
   logic [NUM_DRV-1:0] short_flag;
   logic [NUM_DRV-1:0] supply_prev_ff;
   logic [NUM_DRV-1:0] short_prev_ff;
   logic [NUM_DRV-1:0] shut;
   logic [DATA_W-1:0] ctrl_view;
   logic kill_all;
   logic global_out_ff;
   logic powered_ff;
   hbd_drive_t drive [NUM_DRV];

   // A scope bit at 0 turns the driver's own overcurrent into a shutdown of every bridge.
   assign kill_all = |(oc_now & ~scope_ff);

   genvar d;
   for (d = 0; d < NUM_DRV; d++) begin : g_drv
      localparam int B = drv_base(d);
      logic wr_byte;
      logic [7:0] wbyte;

      assign wr_byte = wr_ctrl && w_strb_ff[B/8];
      assign wbyte = w_data_ff[B +: 8];
      assign oc_now[d] = sense_s[d].overcurrent;
      assign shut[d] = oc_now[d] || kill_all || global_s;
      assign supply_flag[d] = sense_s[d].drain_supply_flag | sense_s[d].pump_supply_flag;
      // A short reading is only trusted while the high-side diag enable is set, whether or not that driver is powered.
      assign short_flag[d] = sense_s[d].short_seen && diag_ff[IDX_HIGH1];

      // Only the type-3 reset restores the stored fields.
      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) begin
            scope_ff[d] <= RESET_OTHER;
            diag_ff[d] <= RESET_OTHER;
            power_ff[d] <= RESET_POWER;
         end else if (wr_byte) begin
            scope_ff[d] <= wbyte[F_SCOPE];
            diag_ff[d] <= wbyte[F_DIAG];
            power_ff[d] <= wbyte[F_POWER];
         end
      end

      // Hardware shutdown beats a software write in the same cycle, for safety.
      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) begin
            on_ff[d] <= RESET_OTHER;
            pwm_ff[d] <= RESET_OTHER;
         end else if (shut[d]) begin
            on_ff[d] <= 1'b0;
            pwm_ff[d] <= 1'b0;
         end else if (wr_byte) begin
            on_ff[d] <= wbyte[F_ON];
            pwm_ff[d] <= wbyte[F_PWM];
         end
      end

      // The flag is re-armed by writing the on bit to 1 once the fault is gone; a fault still
      // present keeps it set.
      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) begin
            ocflag_ff[d] <= RESET_OTHER;
         end else if (oc_now[d]) begin
            ocflag_ff[d] <= 1'b1;
         end else if (wr_byte && wbyte[F_ON]) begin
            ocflag_ff[d] <= 1'b0;
         end
      end

      // Gate drive needs power, the on flag and, when selected, the PWM input high.
      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) begin
            gate_ff[d] <= 1'b0;
         end else begin
            gate_ff[d] <= power_ff[d] && on_ff[d] && !ocflag_ff[d] && !shut[d]
                          && (!pwm_ff[d] || pwm_s);
         end
      end

      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) begin
            supply_prev_ff[d] <= 1'b0;
            short_prev_ff[d] <= 1'b0;
         end else begin
            supply_prev_ff[d] <= supply_flag[d];
            short_prev_ff[d] <= short_flag[d];
         end
      end

      assign drive[d].power = power_ff[d];
      assign drive[d].gate = gate_ff[d];
      // No low-side current source exists, so that enable is kept for read-back only.
      assign drive[d].diag_source = (d == IDX_HIGH1) ? (diag_ff[d] && power_ff[d]) : 1'b0;

      assign ctrl_view[B+F_SCOPE] = scope_ff[d];
      assign ctrl_view[B+F_OCFLAG] = ocflag_ff[d];
      assign ctrl_view[B+F_SUPPLY] = supply_flag[d];
      assign ctrl_view[B+F_SHORT] = short_flag[d];
      assign ctrl_view[B+F_DIAG] = diag_ff[d];
      assign ctrl_view[B+F_ON] = on_ff[d];
      assign ctrl_view[B+F_PWM] = pwm_ff[d];
      assign ctrl_view[B+F_POWER] = power_ff[d];
   end

   // Bytes of the other drivers are not part of this slice and read as zero.
   assign ctrl_view[LOW2_BASE-1:0] = '0;
   assign ctrl_view[DATA_W-1:HIGH1_BASE+8] = '0;

   assign HIGH1_DRIVE = drive[IDX_HIGH1];
   assign LOW2_DRIVE = drive[IDX_LOW2];

   // ----------------------------------------------------------------
   // Bridge-level outputs
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         global_out_ff <= 1'b0;
      end else begin
         global_out_ff <= kill_all;
      end
   end

   // The bridge module may be enabled only while every driver here is powered.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         powered_ff <= 1'b0;
      end else begin
         powered_ff <= &power_ff;
      end
   end

   assign GLOBAL_SHUTDOWN_OUT = global_out_ff;
   assign ALL_DRIVERS_POWERED = powered_ff;

   // ----------------------------------------------------------------
   // Interrupt events
   // ----------------------------------------------------------------
   logic [NUM_EV-1:0] events;
   logic [NUM_EV-1:0] irq_status;
   logic [NUM_EV-1:0] irq_mask;
   logic rd_take;
   logic rd_clear;
   hbd_sel_t rd_sel;

   assign events[EV_OC_LSB +: NUM_DRV] = oc_now & ~ocflag_ff;
   assign events[EV_SUP_LSB +: NUM_DRV] = supply_flag & ~supply_prev_ff;
   assign events[EV_SHORT_LSB +: NUM_DRV] = short_flag & ~short_prev_ff;

   assign rd_take = S_AXI_ARVALID && !S_AXI_RVALID;
   assign rd_sel = decode_addr(S_AXI_ARADDR);
   assign rd_clear = rd_take && (rd_sel == HBD_SEL_IRQ_STS);

   hbd_irq u_irq (
      .clk(CLK),
      .rst_n(RST_N),
      .events(events),
      .read_clear(rd_clear),
      .mask_write(do_write && (wr_sel == HBD_SEL_IRQ_MASK) && w_strb_ff[0]),
      .mask_data(w_data_ff[NUM_EV-1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(IRQ)
   );

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   logic rvalid_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [DATA_W-1:0] rd_word;

   always_comb begin
      rd_word = '0;
      unique case (rd_sel)
         HBD_SEL_CTRL: rd_word = ctrl_view;
         HBD_SEL_IRQ_STS: rd_word[NUM_EV-1:0] = irq_status;
         HBD_SEL_IRQ_MASK: rd_word[NUM_EV-1:0] = irq_mask;
         HBD_SEL_NONE: rd_word = '0;
      endcase
   end

   // The data is captured at acceptance, so status read and clear see the same snapshot.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else if (rd_take) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_word;
         rresp_ff <= (rd_sel == HBD_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (S_AXI_RREADY) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign S_AXI_ARREADY = !rvalid_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;

endmodule

// *** testbench/hbd_slice_assertions.sv ***
/*
 * Concurrent checks on the ports of the bridge driver control slice.
 * Assumes it is bound to hbd_slice and that every port it sees is connected by name.
 */
`timescale 1ns/1ps
module hbd_slice_assertions import hbd_pkg::*; (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [DATA_W-1:0] S_AXI_RDATA,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire hbd_sense_t HIGH1_SENSE,
   input wire hbd_sense_t LOW2_SENSE,
   input wire logic GLOBAL_SHUTDOWN_IN,
   input wire hbd_drive_t HIGH1_DRIVE,
   input wire hbd_drive_t LOW2_DRIVE,
   input wire logic GLOBAL_SHUTDOWN_OUT,
   input wire logic ALL_DRIVERS_POWERED
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   a_low_diag_dead: assert property (!LOW2_DRIVE.diag_source)
      else $error("low side diag source driven");
   a_diag_needs_power: assert property (HIGH1_DRIVE.diag_source |-> HIGH1_DRIVE.power)
      else $error("diag source on without power");
   a_oc_cuts_gate: assert property (HIGH1_SENSE.overcurrent [*6] |=> !HIGH1_DRIVE.gate)
      else $error("gate still on during overcurrent");
   a_global_in_off: assert property (GLOBAL_SHUTDOWN_IN [*6] |=> !HIGH1_DRIVE.gate && !LOW2_DRIVE.gate)
      else $error("gate on during global shutdown");
   a_global_out_cause: assert property ((!HIGH1_SENSE.overcurrent && !LOW2_SENSE.overcurrent) [*8]
      |=> !GLOBAL_SHUTDOWN_OUT) else $error("global shutdown without overcurrent");
   a_all_powered: assert property (ALL_DRIVERS_POWERED |-> $past(HIGH1_DRIVE.power) && $past(LOW2_DRIVE.power))
      else $error("all powered while a driver is off");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data not held");
   a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response not held");
endmodule

// *** testbench/hbd_fet_model.sv ***
/*
 * Behavioural external FET half bridges and PWM source facing the slice.
 * Assumes the bench sets fault levels; no timing of real FETs is modelled.
 */
`timescale 1ns/1ps
module hbd_fet_model import hbd_pkg::*; (
   input wire logic [3:0] fault_high1,
   input wire logic [3:0] fault_low2,
   input wire logic pwm_level,
   input wire hbd_drive_t high1_drive,
   output hbd_sense_t high1_sense,
   output hbd_sense_t low2_sense,
   output logic pwm_out
);
   // ----------------------------------------------------------------
   // Sense levels
   // ----------------------------------------------------------------
   // A short is only seen while the high-side diagnosis current flows, so a short hides without it.
   assign high1_sense = {fault_high1[3:1], fault_high1[0] & high1_drive.diag_source};
   assign low2_sense = {fault_low2[3:1], fault_low2[0] & high1_drive.diag_source};
   assign pwm_out = pwm_level;
endmodule

// *** testbench/tb_top.sv ***
/*
 * Self-checking bench of the bridge driver control slice with a FET model.
 * Assumes the checker file is compiled first; expected results go through a queue.
 */
`timescale 1ns/1ps
module tb_top import hbd_pkg::*; ;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic pwm_cmd = 0, gsd_in = 0, pwm, awready, wready, bvalid, arready, rvalid, gsd_out, all_pwr, irq;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, v;
   logic [3:0] wstrb = 0, flt_h1 = 0, flt_l2 = 0;
   logic [1:0] bresp, rresp;
   hbd_sense_t h1_sense, l2_sense;
   hbd_drive_t h1_drive, l2_drive;
   int err_count = 0, checks = 0, seed = 28;
   logic [33:0] notes[$];

   always #5 clk = ~clk;

   hbd_slice DUT (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PWM_IN(pwm),
      .HIGH1_SENSE(h1_sense), .LOW2_SENSE(l2_sense), .GLOBAL_SHUTDOWN_IN(gsd_in), .HIGH1_DRIVE(h1_drive),
      .LOW2_DRIVE(l2_drive), .GLOBAL_SHUTDOWN_OUT(gsd_out), .ALL_DRIVERS_POWERED(all_pwr), .IRQ(irq));

   hbd_fet_model u_fet (.fault_high1(flt_h1), .fault_low2(flt_l2), .pwm_level(pwm_cmd),
      .high1_drive(h1_drive), .high1_sense(h1_sense), .low2_sense(l2_sense), .pwm_out(pwm));

   // ----------------------------------------------------------------
   // Tasks and monitor
   // ----------------------------------------------------------------
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [33:0] ok(input logic [31:0] d);
      return {RESP_OKAY, d};
   endfunction

   // Answer ready is offered with the request and stands until the answer has been taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      logic aw_go, w_go, b_go;
      notes.push_back({r, 32'h0000_0000});
      @(posedge clk);
      {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'b111};
      do begin
         @(negedge clk);
         {aw_go, w_go, b_go} = {awvalid & awready, wvalid & wready, bvalid & bready};
         @(posedge clk);
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
         bready <= !b_go;
      end while (!b_go);
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      logic ar_go, r_go;
      notes.push_back(e);
      @(posedge clk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do begin
         @(negedge clk);
         {ar_go, r_go} = {arvalid & arready, rvalid & rready};
         @(posedge clk);
         if (ar_go) arvalid <= 1'b0;
         rready <= !r_go;
      end while (!r_go);
   endtask

   // Pins pass a filter of a few edges, so levels are judged after a settled wait.
   task automatic settle;
      repeat (8) @(negedge clk);
   endtask

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   always @(negedge clk) begin
      if (rvalid && rready) chk({rresp, rdata}, notes.pop_front());
      if (bvalid && bready) chk({bresp, 32'h0000_0000}, notes.pop_front());
   end

   initial begin
      #100000;
      err_count++;
      give_verdict;
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_CTRL_ONE, ok(32'h0001_0100));
      rd(OFS_IRQ_MASK, ok(32'h0000_0000));
      for (int i = 0; i < 6; i++) begin
         v = $random(seed);
         wr(OFS_CTRL_ONE, v, 4'hF, RESP_OKAY);
         rd(OFS_CTRL_ONE, ok(v & 32'h008F_8F00));
      end
      wr(OFS_CTRL_ONE, 32'hFFFF_FFFF, 4'h4, RESP_OKAY);
      rd(OFS_CTRL_ONE, ok((v & 32'h0000_8F00) | 32'h008F_0000));
      wr(OFS_CTRL_ONE, 32'h008D_0D00, 4'hF, RESP_OKAY);
      settle;
      chk(h1_drive, 3'b111);
      chk(l2_drive, 3'b110);
      chk(all_pwr, 1'b1);
      wr(OFS_CTRL_ONE, 32'h008F_0D00, 4'hF, RESP_OKAY);
      settle;
      chk(h1_drive.gate, 1'b0);
      @(posedge clk);
      pwm_cmd <= 1'b1;
      flt_h1 <= 4'b0100;
      flt_l2 <= 4'b0010;
      settle;
      chk(h1_drive.gate, 1'b1);
      chk(irq, 1'b0);
      rd(OFS_CTRL_ONE, ok(32'h00AF_2D00));
      wr(OFS_IRQ_MASK, 32'h0000_003F, 4'hF, RESP_OKAY);
      settle;
      chk(irq, 1'b1);
      rd(OFS_IRQ_STATUS, ok(32'h0000_000C));
      rd(OFS_IRQ_STATUS, ok(32'h0000_0000));
      @(posedge clk);
      flt_h1 <= 4'b0001;
      flt_l2 <= 4'b0001;
      settle;
      rd(OFS_CTRL_ONE, ok(32'h009F_1D00));
      wr(OFS_CTRL_ONE, 32'h0087_0D00, 4'hF, RESP_OKAY);
      settle;
      rd(OFS_CTRL_ONE, ok(32'h0087_0D00));
      rd(OFS_IRQ_STATUS, ok(32'h0000_0030));
      @(posedge clk);
      flt_h1 <= 4'b1000;
      flt_l2 <= 4'b0000;
      settle;
      chk({gsd_out, h1_drive.gate, l2_drive.gate}, 3'b001);
      rd(OFS_CTRL_ONE, ok(32'h00C1_0D00));
      rd(OFS_IRQ_STATUS, ok(32'h0000_0001));
      @(posedge clk);
      flt_h1 <= 4'b0000;
      settle;
      wr(OFS_CTRL_ONE, 32'h0087_0D00, 4'hF, RESP_OKAY);
      rd(OFS_CTRL_ONE, ok(32'h0087_0D00));
      @(posedge clk);
      flt_l2 <= 4'b1000;
      settle;
      chk({gsd_out, h1_drive.gate, l2_drive.gate}, 3'b100);
      rd(OFS_CTRL_ONE, ok(32'h0081_4900));
      @(posedge clk);
      flt_l2 <= 4'b0000;
      settle;
      chk(gsd_out, 1'b0);
      wr(OFS_CTRL_ONE, 32'h0087_0D00, 4'hF, RESP_OKAY);
      @(posedge clk);
      gsd_in <= 1'b1;
      settle;
      chk({h1_drive.gate, l2_drive.gate}, 2'b00);
      @(posedge clk);
      gsd_in <= 1'b0;
      wr(8'h20, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      rd(8'h20, {RESP_SLVERR, 32'h0000_0000});
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_CTRL_ONE, ok(32'h0001_0100));
      give_verdict;
   end
endmodule

bind hbd_slice hbd_slice_assertions u_chk (.CLK(CLK), .RST_N(RST_N), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .HIGH1_SENSE(HIGH1_SENSE), .LOW2_SENSE(LOW2_SENSE),
   .GLOBAL_SHUTDOWN_IN(GLOBAL_SHUTDOWN_IN), .HIGH1_DRIVE(HIGH1_DRIVE), .LOW2_DRIVE(LOW2_DRIVE),
   .GLOBAL_SHUTDOWN_OUT(GLOBAL_SHUTDOWN_OUT), .ALL_DRIVERS_POWERED(ALL_DRIVERS_POWERED));
